// ---- verilog/eamc_regs.sv ----
// Configuration register bank with sign and fault event interrupts
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module eamc_regs (
   // Clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_b_i,
   // APB slave
   input  wire eamc_pkg::eamc_apb_req_t apb_i,
   output logic [31:0]                prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // Metering core status
   input  wire eamc_pkg::eamc_meter_in_t meter_i,
   // Metering core control
   output eamc_pkg::eamc_ctrl_t       ctrl_o,
   // Interrupt
   output logic                       irq_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]          accum_mode;
      logic [7:0]          chan_gain;
      logic [7:0]          cal_mode;
      logic [7:0]          irq_status;
      logic [7:0]          irq_mask;
      logic                prev_active_neg;
      logic                prev_react_neg;
      logic                prev_fault;
      logic                sign_valid;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
      eamc_pkg::eamc_ctrl_t ctrl;
      logic                irq;
   } eamc_state_t;

   eamc_state_t st;
   eamc_state_t next_st;

   // Register index from a byte address; low bits must be zero
   function automatic logic [7:0] eamc_index(input logic [eamc_pkg::ADDR_W-1:0] a);
      eamc_index = a[eamc_pkg::ADDR_W-1:2];
   endfunction : eamc_index

   // Edge select: 0 picks a rise of the flag, 1 a fall
   function automatic logic eamc_edge(input logic sel, input logic prev, input logic now);
      eamc_edge = sel ? (prev & ~now) : (~prev & now);
   endfunction : eamc_edge

   // Unsupported gain codes are clamped so the datapath never sees them
   function automatic logic [2:0] eamc_gain(input logic [2:0] code);
      eamc_gain = (code > eamc_pkg::GAIN_MAX_CODE) ? eamc_pkg::GAIN_MAX_CODE : code;
   endfunction : eamc_gain

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic       acc;
      logic       rd;
      logic       hit;
      logic [7:0] idx;
      logic [7:0] rval;
      logic       act_sample;
      logic       rct_sample;
      logic [7:0] events;
      acc        = 1'b0;
      rd         = 1'b0;
      hit        = 1'b0;
      idx        = 8'h00;
      rval       = 8'h00;
      act_sample = 1'b0;
      rct_sample = 1'b0;
      events     = 8'h00;
      next_st    = st;

      // Access phase answered in one cycle; pready pulses for it
      acc = apb_i.psel & apb_i.penable & ~st.pready;
      idx = eamc_index(apb_i.paddr);
      hit = (apb_i.paddr[1:0] == 2'h0) &&
            (idx == eamc_pkg::IDX_ACCUM_MODE || idx == eamc_pkg::IDX_CHAN_GAIN ||
             idx == eamc_pkg::IDX_CAL_MODE || idx == eamc_pkg::IDX_IRQ_STATUS ||
             idx == eamc_pkg::IDX_IRQ_MASK);
      rd  = acc & ~apb_i.pwrite & hit;

      // Read mux; tamper channel bit is live core state
      case (idx)
         eamc_pkg::IDX_ACCUM_MODE: begin
            rval = st.accum_mode;
            rval[eamc_pkg::BIT_TAMPER_CH] = meter_i.tamper_ch_b;
         end
         eamc_pkg::IDX_CHAN_GAIN:  rval = st.chan_gain;
         eamc_pkg::IDX_CAL_MODE:   rval = st.cal_mode;
         eamc_pkg::IDX_IRQ_STATUS: rval = st.irq_status;
         eamc_pkg::IDX_IRQ_MASK:   rval = st.irq_mask;
         default:                  rval = 8'h00;
      endcase

      next_st.pready  = acc;
      next_st.pslverr = acc & ~hit;
      next_st.prdata  = rd ? {24'h000000, rval} : 32'h00000000;

      // Register writes; reserved bits are held at zero, but cal_mode stores all eight bits
      if (acc && apb_i.pwrite && hit) begin
         case (idx)
            eamc_pkg::IDX_ACCUM_MODE:
               next_st.accum_mode = apb_i.pwdata[7:0] & eamc_pkg::WMASK_ACCUM;
            eamc_pkg::IDX_CHAN_GAIN:
               next_st.chan_gain = apb_i.pwdata[7:0] & eamc_pkg::WMASK_GAIN;
            eamc_pkg::IDX_CAL_MODE:
               next_st.cal_mode = apb_i.pwdata[7:0] & eamc_pkg::WMASK_CAL;
            eamc_pkg::IDX_IRQ_MASK:
               next_st.irq_mask = apb_i.pwdata[7:0] & eamc_pkg::WMASK_IRQ;
            default: next_st.irq_mask = st.irq_mask;
         endcase
      end

      // Sign sampling point: filtered signal or per output pulse
      act_sample = st.chan_gain[eamc_pkg::BIT_SIGN_PLACE] ? meter_i.active_pulse : 1'b1;
      rct_sample = st.chan_gain[eamc_pkg::BIT_SIGN_PLACE] ? meter_i.react_pulse : 1'b1;
      if (act_sample) begin
         next_st.prev_active_neg = meter_i.active_neg;
      end
      if (rct_sample) begin
         next_st.prev_react_neg = meter_i.react_neg;
      end
      next_st.prev_fault = meter_i.fault_mode;
      next_st.sign_valid = 1'b1;

      // Edge events; first cycle after reset only primes history
      if (st.sign_valid) begin
         events[eamc_pkg::BIT_IRQ_ACTIVE] = act_sample &
            eamc_edge(st.accum_mode[eamc_pkg::BIT_ACTIVE_EDGE],
                      st.prev_active_neg, meter_i.active_neg);
         events[eamc_pkg::BIT_IRQ_REACT] = rct_sample &
            eamc_edge(st.accum_mode[eamc_pkg::BIT_REACT_EDGE],
                      st.prev_react_neg, meter_i.react_neg);
         events[eamc_pkg::BIT_IRQ_FAULT] =
            eamc_edge(st.accum_mode[eamc_pkg::BIT_FAULT_EDGE],
                      st.prev_fault, meter_i.fault_mode);
      end

      // Read clears status; a new event in the same cycle wins
      if (rd && idx == eamc_pkg::IDX_IRQ_STATUS) begin
         next_st.irq_status = events;
      end else begin
         next_st.irq_status = st.irq_status | events;
      end
      next_st.irq = |(next_st.irq_status & next_st.irq_mask);

      // Reactive accumulation operation
      if (next_st.accum_mode[eamc_pkg::BIT_REACT_ABS]) begin
         next_st.ctrl.react_op = eamc_pkg::EAMC_ACC_ABS;
      end else if (next_st.accum_mode[eamc_pkg::BIT_SIGN_STEER]) begin
         next_st.ctrl.react_op = meter_i.active_neg ? eamc_pkg::EAMC_ACC_NEG
                                                    : eamc_pkg::EAMC_ACC_PASS;
      end else begin
         next_st.ctrl.react_op = eamc_pkg::EAMC_ACC_PASS;
      end

      // Active accumulation: absolute wins over positive-only
      if (next_st.accum_mode[eamc_pkg::BIT_ACTIVE_ABS]) begin
         next_st.ctrl.active_op = eamc_pkg::EAMC_ACC_ABS;
      end else if (next_st.accum_mode[eamc_pkg::BIT_POS_ONLY]) begin
         next_st.ctrl.active_op = eamc_pkg::EAMC_ACC_POS;
      end else begin
         next_st.ctrl.active_op = eamc_pkg::EAMC_ACC_PASS;
      end

      // Gains, channel selection and input shorts
      next_st.ctrl.voltage_gain  = eamc_gain(next_st.chan_gain[7:5]);
      next_st.ctrl.current_gain  = eamc_gain(next_st.chan_gain[2:0]);
      next_st.ctrl.sign_on_pulse = next_st.chan_gain[eamc_pkg::BIT_SIGN_PLACE];
      case (eamc_pkg::eamc_chan_sel_t'(next_st.cal_mode[5:4]))
         eamc_pkg::EAMC_CH_A: next_st.ctrl.use_input_b = 1'b0;
         eamc_pkg::EAMC_CH_B: next_st.ctrl.use_input_b = 1'b1;
         default:             next_st.ctrl.use_input_b = meter_i.tamper_ch_b;
      endcase
      next_st.ctrl.voltage_short = next_st.cal_mode[eamc_pkg::BIT_V_SHORT];
      next_st.ctrl.current_short = next_st.cal_mode[eamc_pkg::BIT_I_SHORT];
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st            <= '0;
         st.accum_mode <= eamc_pkg::RST_ACCUM_MODE;
         st.chan_gain  <= eamc_pkg::RST_CHAN_GAIN;
         st.cal_mode   <= eamc_pkg::RST_CAL_MODE;
         st.irq_mask   <= eamc_pkg::RST_IRQ_MASK;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flip-flops
   assign prdata_o  = st.prdata;
   assign pready_o  = st.pready;
   assign pslverr_o = st.pslverr;
   assign ctrl_o    = st.ctrl;
   assign irq_o     = st.irq;

endmodule : eamc_regs
`default_nettype wire

// ---- verilog/eamc_pkg.sv ----
// Package of constants and types for the energy accumulation mode configuration bank
package eamc_pkg;

   // ----------------------------------------------------------------
   // Register map: printed offsets are indices, byte address is 4x
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_ACCUM_MODE  = 8'h0F;
   localparam logic [7:0] IDX_CHAN_GAIN   = 8'h1B;
   localparam logic [7:0] IDX_CAL_MODE    = 8'h3D;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h40;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h41;
   localparam int         ADDR_W          = 10;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_TAMPER_CH    = 7;
   localparam int BIT_FAULT_EDGE   = 6;
   localparam int BIT_REACT_EDGE   = 5;
   localparam int BIT_ACTIVE_EDGE  = 4;
   localparam int BIT_REACT_ABS    = 3;
   localparam int BIT_SIGN_STEER   = 2;
   localparam int BIT_POS_ONLY     = 1;
   localparam int BIT_ACTIVE_ABS   = 0;
   localparam int BIT_SIGN_PLACE   = 3;
   localparam int BIT_V_SHORT      = 3;
   localparam int BIT_I_SHORT      = 2;
   localparam int BIT_IRQ_FAULT    = 5;
   localparam int BIT_IRQ_REACT    = 4;
   localparam int BIT_IRQ_ACTIVE   = 3;

   // ----------------------------------------------------------------
   // Reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ACCUM_MODE  = 8'h00;
   localparam logic [7:0] RST_CHAN_GAIN   = 8'h00;
   localparam logic [7:0] RST_CAL_MODE    = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK    = 8'h00;
   localparam logic [7:0] WMASK_ACCUM     = 8'h7F;
   localparam logic [7:0] WMASK_GAIN      = 8'hEF;
   localparam logic [7:0] WMASK_CAL       = 8'hFF;
   localparam logic [7:0] WMASK_IRQ       = 8'h38;
   localparam logic [2:0] GAIN_MAX_CODE   = 3'h4;

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      EAMC_CH_AUTO0 = 2'h0,
      EAMC_CH_A     = 2'h1,
      EAMC_CH_B     = 2'h2,
      EAMC_CH_AUTO3 = 2'h3
   } eamc_chan_sel_t;

   typedef enum logic [1:0] {
      EAMC_ACC_PASS = 2'h0,
      EAMC_ACC_ABS  = 2'h1,
      EAMC_ACC_POS  = 2'h3,
      EAMC_ACC_NEG  = 2'h2
   } eamc_acc_op_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [31:0]       pwdata;
   } eamc_apb_req_t;

   typedef struct packed {
      logic        active_neg;
      logic        react_neg;
      logic        fault_mode;
      logic        active_pulse;
      logic        react_pulse;
      logic        tamper_ch_b;
   } eamc_meter_in_t;

   typedef struct packed {
      eamc_acc_op_t active_op;
      eamc_acc_op_t react_op;
      logic [2:0]   voltage_gain;
      logic [2:0]   current_gain;
      logic         sign_on_pulse;
      logic         use_input_b;
      logic         voltage_short;
      logic         current_short;
   } eamc_ctrl_t;

endpackage : eamc_pkg

// ---- tb/eamc_regs_asserts.sv ----
// Assertion checker for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module eamc_regs_asserts (
   // Clock and reset
   input wire logic                     sys_clk_i,
   input wire logic                     rst_b_i,
   // Bus side
   input wire eamc_pkg::eamc_apb_req_t  apb_i,
   input wire logic [31:0]              prdata_o,
   input wire logic                     pready_o,
   input wire logic                     pslverr_o,
   // Metering side
   input wire eamc_pkg::eamc_meter_in_t meter_i,
   input wire eamc_pkg::eamc_ctrl_t     ctrl_o,
   input wire logic                     irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   // ----------------------------------------
   // Access steps
   // ----------------------------------------
   sequence s_take;
      apb_i.psel && apb_i.penable && !pready_o;
   endsequence
   sequence s_wr_acc;
      s_take ##0 (apb_i.pwrite && apb_i.paddr == 10'h03C);
   endsequence
   sequence s_wr_cal;
      s_take ##0 (apb_i.pwrite && apb_i.paddr == 10'h0F4);
   endsequence

   // Handshake shape: one wait state, one-cycle answer
   a_one_wait: assert property (s_take |=> pready_o)
      else $error("ready missing after one wait state");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_misalign_err: assert property (s_take ##0 (apb_i.paddr[1:0] != 2'h0) |=> pslverr_o)
      else $error("misaligned access not refused");
   a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data outside answer cycle");
   a_reset_quiet: assert property ($rose(rst_b_i) |-> !irq_o && !pready_o)
      else $error("outputs active after reset");
   // Field effects on control outputs
   a_gain_range: assert property (ctrl_o.voltage_gain <= 3'h4 && ctrl_o.current_gain <= 3'h4)
      else $error("gain code beyond largest gain");
   a_abs_first: assert property (s_wr_acc ##0 (apb_i.pwdata[1:0] == 2'h3) |->
      ##[1:3] ctrl_o.active_op == eamc_pkg::EAMC_ACC_ABS)
      else $error("absolute mode lost priority");
   a_force_a: assert property (s_wr_cal ##0 (apb_i.pwdata[5:4] == 2'h1) |->
      ##2 !ctrl_o.use_input_b)
      else $error("forced input A not applied");
   a_v_short: assert property (s_wr_cal ##0 apb_i.pwdata[3] |-> ##2 ctrl_o.voltage_short)
      else $error("voltage short not applied");
endmodule : eamc_regs_asserts

bind eamc_regs eamc_regs_asserts eamc_regs_asserts_i (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .apb_i(apb_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .meter_i(meter_i), .ctrl_o(ctrl_o),
   .irq_o(irq_o));
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                     sys_clk_i;
   logic                     rst_b_i;
   eamc_pkg::eamc_apb_req_t  apb;
   eamc_pkg::eamc_meter_in_t meter;
   eamc_pkg::eamc_ctrl_t     ctrl;
   logic [31:0]              prdata;
   logic [31:0]              rd_val;
   logic                     pready;
   logic                     pslverr;
   logic                     irq;
   logic                     err_seen;
   int                       err_total;
   int                       n_compared;
   int                       cyc = 0;
   logic [7:0]               acc_v [6] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h0C, 8'h04};
   logic [3:0]               acc_e [6] = '{4'h4, 4'hC, 4'h4, 4'h1, 4'h1, 4'h0};
   logic [7:0]               cal_v [4] = '{8'h24, 8'h18, 8'h00, 8'h30};
   logic [2:0]               cal_e [4] = '{3'h5, 3'h2, 3'h4, 3'h4};

   eamc_regs eamc_regs_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .apb_i(apb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .meter_i(meter),
      .ctrl_o(ctrl), .irq_o(irq));

   // 250 MHz clock
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total = err_total + 1;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer, request held until ready is sampled high
   task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
      @(posedge sys_clk_i);
      apb.penable <= 1'b1;
      @(posedge sys_clk_i);
      while (pready !== 1'b1) @(posedge sys_clk_i);
      rd_val = prdata;
      err_seen = pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd_val, exp);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : tick

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   // Main sequence
   initial begin
      rst_b_i = 1'b0;
      apb = '0;
      meter = '0;
      err_total = 0;
      n_compared = 0;
      tick(20);
      rst_b_i <= 1'b1;
      rd(10'h03C, 32'h0);
      rd(10'h06C, 32'h0);
      rd(10'h0F4, 32'h0);
      chk(32'(ctrl), 32'h0);
      $display("reset test done");
      // Largest gain codes, reserved bit 4 dropped, upper data ignored
      wr(10'h06C, 32'hFFFF_FF9C);
      rd(10'h06C, 32'h8C);
      chk(32'({ctrl.voltage_gain, ctrl.current_gain, ctrl.sign_on_pulse}), 32'h49);
      // Codes above the largest gain must be clamped, not passed on
      wr(10'h06C, 32'h0000_00FF);
      rd(10'h06C, 32'hEF);
      chk(32'({ctrl.voltage_gain, ctrl.current_gain, ctrl.sign_on_pulse}), 32'h49);
      $display("gain test done");
      for (int i = 0; i < 6; i++) begin
         wr(10'h03C, {24'h0, acc_v[i]});
         tick(1);
         chk(32'({ctrl.active_op, ctrl.react_op}), 32'(acc_e[i]));
      end
      meter.active_neg <= 1'b1;
      tick(3);
      chk(32'(ctrl.react_op), 32'h2);
      // Tamper report is live and ignores writes
      meter.tamper_ch_b <= 1'b1;
      wr(10'h03C, 32'h0);
      rd(10'h03C, 32'h80);
      $display("accumulation test done");
      for (int i = 0; i < 4; i++) begin
         wr(10'h0F4, {24'h0, cal_v[i]});
         rd(10'h0F4, {24'h0, cal_v[i]});
         chk(32'({ctrl.use_input_b, ctrl.voltage_short, ctrl.current_short}), 32'(cal_e[i]));
      end
      $display("calibration test done");
      xfer(1'b0, 10'h200, 32'h0);
      chk({rd_val[30:0], err_seen}, 32'h1);
      xfer(1'b1, 10'h03D, 32'hFF);
      chk(32'(err_seen), 32'h1);
      rd(10'h03C, 32'h80);
      $display("refusal test done");
      // Fault on return to normal, sign events on falling power
      // Filtered sign detection first, else no sign event without pulses
      wr(10'h06C, 32'h04);
      wr(10'h03C, 32'h40);
      xfer(1'b0, 10'h100, 32'h0);
      wr(10'h104, 32'h38);
      meter.active_neg <= 1'b0;
      meter.fault_mode <= 1'b1;
      tick(3);
      chk(32'(irq), 32'h0);
      meter.active_neg <= 1'b1;
      meter.fault_mode <= 1'b0;
      meter.react_neg <= 1'b1;
      tick(3);
      chk(32'(irq), 32'h1);
      rd(10'h100, 32'h38);
      tick(2);
      chk(32'(irq), 32'h0);
      // Masked fault entry still sets status
      wr(10'h104, 32'h10);
      wr(10'h03C, 32'h0);
      meter.fault_mode <= 1'b1;
      tick(3);
      chk(32'(irq), 32'h0);
      rd(10'h100, 32'h20);
      rd(10'h104, 32'h10);
      $display("interrupt test done");
      // Per-pulse detection, events on negative-to-positive sign changes
      wr(10'h06C, 32'h0C);
      wr(10'h03C, 32'h30);
      wr(10'h104, 32'h18);
      meter.active_neg <= 1'b0;
      meter.react_neg <= 1'b0;
      tick(3);
      chk(32'(irq), 32'h0);
      meter.active_pulse <= 1'b1;
      meter.react_pulse <= 1'b1;
      tick(1);
      meter.active_pulse <= 1'b0;
      meter.react_pulse <= 1'b0;
      tick(2);
      chk(32'(irq), 32'h1);
      rd(10'h100, 32'h18);
      $display("pulse sign test done");
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
